// ### ejau_consts.vh
// Constants for the engine jump and arithmetic unit: register offsets,
// instruction field positions, opcodes and reset values.
// Assumes it is included by the design file by its bare name.
`ifndef EJAU_CONSTS_VH
`define EJAU_CONSTS_VH

// ========================================
// Register byte offsets.
`define EJAU_OFS_INSTR   8'h00
`define EJAU_OFS_STATUS  8'h04
`define EJAU_OFS_PC0     8'h08
`define EJAU_OFS_PC1     8'h0C
`define EJAU_OFS_PC2     8'h10
`define EJAU_OFS_VARS0   8'h14
`define EJAU_OFS_VARS1   8'h18
`define EJAU_OFS_VARS2   8'h1C
`define EJAU_OFS_GLOBAL  8'h20
`define EJAU_OFS_DVAR    8'h24
`define EJAU_OFS_ALTVAL  8'h28
`define EJAU_OFS_CFG     8'h2C

// ========================================
// Instruction word field positions.
`define EJAU_OP_HI    2
`define EJAU_OP_LO    0
`define EJAU_ENG_HI   5
`define EJAU_ENG_LO   4
`define EJAU_TGT_HI   9
`define EJAU_TGT_LO   8
`define EJAU_SRC1_HI  11
`define EJAU_SRC1_LO  10
`define EJAU_SRC2_HI  13
`define EJAU_SRC2_LO  12
`define EJAU_SKIP_HI  20
`define EJAU_SKIP_LO  16
`define EJAU_IMM_HI   31
`define EJAU_IMM_LO   24

// ========================================
// Opcodes.
`define EJAU_OPC_NOP       3'h0
`define EJAU_OPC_SKIP_NE   3'h1
`define EJAU_OPC_SKIP_LO   3'h2
`define EJAU_OPC_SKIP_GE   3'h3
`define EJAU_OPC_SKIP_EQ   3'h4
`define EJAU_OPC_LOAD      3'h5
`define EJAU_OPC_ADD_IMM   3'h6
`define EJAU_OPC_ADD_VARS  3'h7

// ========================================
// Operand selector codes and reset values.
`define EJAU_SEL_A       2'h0
`define EJAU_SEL_B       2'h1
`define EJAU_SEL_C       2'h2
`define EJAU_SEL_D       2'h3
`define EJAU_NUM_ENG     2'h3
`define EJAU_RST_VAR     8'h00
`define EJAU_RST_PC      7'h00
`define EJAU_HSIZE_WORD  3'h2

`endif

// ### ejau_top.v
// Jump and arithmetic unit of the lighting program engines, as an AHB-Lite slave.
// Assumes a single-master AHB-Lite bus on ref_clk; every bus input is synchronous.
//
// Contract
// - Four compare jumps: ne, lower, ge, equal.
// - True compare moves counter forward by skip.
// - False compare goes to next instruction.
// - Skip is five bits; zero skips nothing.
// - Source codes: A, B, global, D value.
// - Load overwrites target with the immediate.
// - Each engine owns private variables A, B.
// - One global variable C shared by engines.
// - Target codes A, B, C; eight-bit immediate.
// - Add immediate to target, store in target.
// - Add two sources, store in target.
// - Sums wrap modulo 256.
`timescale 1ns/100ps
`include "ejau_consts.vh"

module ejau_top (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp
);

  // ========================================
  // Bus front end state.
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RDWT = 2'b10;

  reg [1:0]  state_reg;
  reg [7:0]  addr_reg;
  reg        wrPend_reg;

  // ========================================
  // Engine state: private variables and counters, one slot per engine.
  reg [7:0]  varA_reg [0:2];
  reg [7:0]  varB_reg [0:2];
  reg [6:0]  pc_reg   [0:2];
  reg [7:0]  globalC_reg;
  reg [7:0]  dVar_reg;
  reg [7:0]  altVal_reg;
  reg        cfgAlt_reg;
  reg [31:0] lastInstr_reg;
  reg        lastTaken_reg;
  reg        lastRejected_reg;
  reg [7:0]  lastResult_reg;

  // ========================================
  // Decoded fields of the instruction being written.
  wire [2:0] op    = hwdata[`EJAU_OP_HI:`EJAU_OP_LO];
  wire [1:0] eng   = hwdata[`EJAU_ENG_HI:`EJAU_ENG_LO];
  wire [1:0] tgt   = hwdata[`EJAU_TGT_HI:`EJAU_TGT_LO];
  wire [1:0] src1  = hwdata[`EJAU_SRC1_HI:`EJAU_SRC1_LO];
  wire [1:0] src2  = hwdata[`EJAU_SRC2_HI:`EJAU_SRC2_LO];
  wire [4:0] skip  = hwdata[`EJAU_SKIP_HI:`EJAU_SKIP_LO];
  wire [7:0] imm   = hwdata[`EJAU_IMM_HI:`EJAU_IMM_LO];

  // A write commits at the end of its data phase.
  wire       wrDo     = wrPend_reg & hready;
  wire       wrInstr  = wrDo & (addr_reg == `EJAU_OFS_INSTR);
  wire       engOk    = (eng < `EJAU_NUM_ENG);
  wire       execDo   = wrInstr & engOk;

  // The D operand is either the variable register or the alternate value.
  wire [7:0] dValue   = cfgAlt_reg ? altVal_reg : dVar_reg;

  // ========================================
  // Operand selection, seen only from the addressed engine.
  reg  [7:0] src1Val;
  reg  [7:0] src2Val;
  reg  [7:0] tgtVal;
  reg  [1:0] engIdx;

  always @* begin
    engIdx = engOk ? eng : 2'h0;
    case (src1)
      `EJAU_SEL_A: src1Val = varA_reg[engIdx];
      `EJAU_SEL_B: src1Val = varB_reg[engIdx];
      `EJAU_SEL_C: src1Val = globalC_reg;
      default:     src1Val = dValue;
    endcase
    case (src2)
      `EJAU_SEL_A: src2Val = varA_reg[engIdx];
      `EJAU_SEL_B: src2Val = varB_reg[engIdx];
      `EJAU_SEL_C: src2Val = globalC_reg;
      default:     src2Val = dValue;
    endcase
    case (tgt)
      `EJAU_SEL_A: tgtVal = varA_reg[engIdx];
      `EJAU_SEL_B: tgtVal = varB_reg[engIdx];
      default:     tgtVal = globalC_reg;
    endcase
  end

  // ========================================
  // Compare and arithmetic. Operands are plain unsigned bytes.
  wire       isEq = (src1Val == src2Val);
  wire       isLo = (src1Val < src2Val);
  reg        isJump;
  reg        taken;
  reg        isWrite;
  reg  [7:0] result_next;

  always @* begin
    isJump      = 1'b0;
    taken       = 1'b0;
    isWrite     = 1'b0;
    result_next = 8'h00;
    case (op)
      `EJAU_OPC_SKIP_NE: begin
        isJump = 1'b1;
        taken  = ~isEq;
      end
      `EJAU_OPC_SKIP_LO: begin
        isJump = 1'b1;
        taken  = isLo;
      end
      `EJAU_OPC_SKIP_GE: begin
        isJump = 1'b1;
        taken  = ~isLo;
      end
      `EJAU_OPC_SKIP_EQ: begin
        isJump = 1'b1;
        taken  = isEq;
      end
      `EJAU_OPC_LOAD: begin
        isWrite     = 1'b1;
        result_next = imm;
      end
      `EJAU_OPC_ADD_IMM: begin
        isWrite     = 1'b1;
        result_next = tgtVal + imm;
      end
      `EJAU_OPC_ADD_VARS: begin
        isWrite     = 1'b1;
        result_next = src1Val + src2Val;
      end
      default: begin
        isJump = 1'b0;
      end
    endcase
  end

  // A target code of 3 names no variable; the write is dropped.
  wire       tgtOk   = (tgt != `EJAU_SEL_D);
  wire       varWr   = execDo & isWrite & tgtOk;
  wire       rejDo   = wrInstr & (~engOk | (isWrite & ~tgtOk));

  // Counter step: one past the jump, plus the skip count when taken.
  // The counter is seven bits and wraps modulo 128; software reloads it by register.
  wire [6:0] pcCur   = pc_reg[engIdx];
  wire [6:0] pcStep  = (isJump & taken) ? {2'b00, skip} : 7'h00;
  wire [6:0] pc_next = pcCur + 7'h01 + pcStep;

  // ========================================
  // Engine state update. Instruction writes and direct software writes
  // never meet in one cycle, since the bus commits one word at a time.
  // Engine code 3, and target code 3 on a load or add, are refused: they raise the rejected flag and
  // leave every variable alone, though a refused target still steps the counter.
  integer i;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        varA_reg[i] <= `EJAU_RST_VAR;
        varB_reg[i] <= `EJAU_RST_VAR;
        pc_reg[i]   <= `EJAU_RST_PC;
      end
      globalC_reg      <= `EJAU_RST_VAR;
      dVar_reg         <= `EJAU_RST_VAR;
      altVal_reg       <= `EJAU_RST_VAR;
      cfgAlt_reg       <= 1'b0;
      lastInstr_reg    <= 32'h0000_0000;
      lastTaken_reg    <= 1'b0;
      lastRejected_reg <= 1'b0;
      lastResult_reg   <= `EJAU_RST_VAR;
    end else begin
      if (execDo && op != `EJAU_OPC_NOP) begin
        pc_reg[engIdx] <= pc_next;
        lastTaken_reg  <= isJump & taken;
      end
      if (varWr) begin
        lastResult_reg <= result_next;
        case (tgt)
          `EJAU_SEL_A: varA_reg[engIdx] <= result_next;
          `EJAU_SEL_B: varB_reg[engIdx] <= result_next;
          default:     globalC_reg      <= result_next;
        endcase
      end
      if (wrInstr) begin
        lastInstr_reg    <= hwdata;
        lastRejected_reg <= rejDo;
      end
      if (wrDo) begin
        case (addr_reg)
          `EJAU_OFS_PC0:    pc_reg[0]   <= hwdata[6:0];
          `EJAU_OFS_PC1:    pc_reg[1]   <= hwdata[6:0];
          `EJAU_OFS_PC2:    pc_reg[2]   <= hwdata[6:0];
          `EJAU_OFS_VARS0: begin
            varA_reg[0] <= hwdata[7:0];
            varB_reg[0] <= hwdata[15:8];
          end
          `EJAU_OFS_VARS1: begin
            varA_reg[1] <= hwdata[7:0];
            varB_reg[1] <= hwdata[15:8];
          end
          `EJAU_OFS_VARS2: begin
            varA_reg[2] <= hwdata[7:0];
            varB_reg[2] <= hwdata[15:8];
          end
          `EJAU_OFS_GLOBAL: globalC_reg <= hwdata[7:0];
          `EJAU_OFS_DVAR:   dVar_reg    <= hwdata[7:0];
          `EJAU_OFS_ALTVAL: altVal_reg  <= hwdata[7:0];
          `EJAU_OFS_CFG:    cfgAlt_reg  <= hwdata[0];
          default:          cfgAlt_reg  <= cfgAlt_reg;
        endcase
      end
    end
  end

  // ========================================
  // Read multiplexer; unmapped offsets read as zero.
  // STATUS packs the last result in [15:8], rejected in bit 1 and taken in bit 0.
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    case (addr_reg)
      `EJAU_OFS_INSTR:  rd_next = lastInstr_reg;
      `EJAU_OFS_STATUS: rd_next = {16'h0000, lastResult_reg, 6'h00,
                                   lastRejected_reg, lastTaken_reg};
      `EJAU_OFS_PC0:    rd_next = {25'h000_0000, pc_reg[0]};
      `EJAU_OFS_PC1:    rd_next = {25'h000_0000, pc_reg[1]};
      `EJAU_OFS_PC2:    rd_next = {25'h000_0000, pc_reg[2]};
      `EJAU_OFS_VARS0:  rd_next = {16'h0000, varB_reg[0], varA_reg[0]};
      `EJAU_OFS_VARS1:  rd_next = {16'h0000, varB_reg[1], varA_reg[1]};
      `EJAU_OFS_VARS2:  rd_next = {16'h0000, varB_reg[2], varA_reg[2]};
      `EJAU_OFS_GLOBAL: rd_next = {24'h00_0000, globalC_reg};
      `EJAU_OFS_DVAR:   rd_next = {24'h00_0000, dVar_reg};
      `EJAU_OFS_ALTVAL: rd_next = {24'h00_0000, altVal_reg};
      `EJAU_OFS_CFG:    rd_next = {31'h0000_0000, cfgAlt_reg};
      default:          rd_next = 32'h0000_0000;
    endcase
  end

  // ========================================
  // AHB-Lite slave. Reads take one wait state so the data is always
  // registered from settled state, including a write committed just before.
  // Narrow writes are dropped; narrow reads are answered with the whole word.
  wire       addrPh  = hsel & htrans[1] & hready;
  wire       sizeOk  = (hsize == `EJAU_HSIZE_WORD);

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= ST_IDLE;
      addr_reg   <= 8'h00;
      wrPend_reg <= 1'b0;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      hresp <= 1'b0; // Every transfer answers OKAY.
      case (state_reg)
        ST_IDLE: begin
          if (hready) begin
            wrPend_reg <= addrPh & hwrite & sizeOk;
          end
          if (addrPh) begin
            addr_reg <= {haddr[7:2], 2'b00};
            if (!hwrite) begin
              state_reg <= ST_RDWT;
              hreadyout <= 1'b0;
            end
          end
        end
        ST_RDWT: begin
          // The size is long gone by now, so every read gets the full word.
          hrdata    <= rd_next;
          hreadyout <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule // ejau_top

// ### ejau_monitor.sv
// Checker for the jump and arithmetic unit, watching only its bus ports.
// Assumes it is bound to ejau_top, with hready fed back from hreadyout.
`timescale 1ns/100ps
module ejau_monitor (
  input logic        ref_clk,
  input logic        sys_rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [2:0]  hsize,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp
);
  logic        aWr;
  logic        aRd;
  logic [7:0]  aAd;
  logic [31:0] lastIns;
  logic        insLast;
  wire         rdDone = aRd & hready;
  wire         isLd = lastIns[2:0] == 3'h5 && lastIns[5:4] != 2'h3 && insLast;
  // ========================================
  // Data phase tracking. Only the latest write matters, since any other write may move a variable.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aWr <= 1'b0;
      aRd <= 1'b0;
      aAd <= 8'h00;
      lastIns <= 32'h0000_0000;
      insLast <= 1'b0;
    end else if (hready) begin
      aWr <= hsel & htrans[1] & hwrite;
      aRd <= hsel & htrans[1] & ~hwrite;
      aAd <= haddr[7:0];
      if (aWr) begin
        insLast <= aAd == 8'h00;
        lastIns <= (aAd == 8'h00) ? hwdata : lastIns;
      end
    end
  end
  // ========================================
  // Properties.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
  a_read_wait: assert property (hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (hready && hsel && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0) else $error("read data moved");
  a_load_status: assert property (rdDone && aAd == 8'h04 && isLd && lastIns[9:8] != 2'h3
    |-> hrdata[15:8] == lastIns[31:24]) else $error("status result wrong after load");
  a_nonjump_flag: assert property (rdDone && aAd == 8'h04 && lastIns[2:0] >= 3'h5 && lastIns[5:4] != 2'h3
    |-> hrdata[0] == 1'b0) else $error("jump flag set by arithmetic");
  a_load_global: assert property (rdDone && aAd == 8'h20 && isLd && lastIns[9:8] == 2'h2
    |-> hrdata[7:0] == lastIns[31:24]) else $error("global not loaded");
  a_load_local: assert property (rdDone && aAd == 8'h14 + {lastIns[5:4], 2'b00} && isLd && !lastIns[9]
    |-> hrdata[{lastIns[8], 3'b000} +: 8] == lastIns[31:24]) else $error("local not loaded");
  c_read: cover property (rdDone);
  c_load: cover property (rdDone && isLd);
  c_jump: cover property (aWr && aAd == 8'h00 && hwdata[2:0] == 3'h4);
endmodule // ejau_monitor

// ### ejau_testbench.sv
// Self-checking bench for the jump and arithmetic unit, driving its bus directly.
// Assumes ejau_top, ejau_monitor and ejau_consts.vh are compiled alongside.
`timescale 1ns/100ps
`include "ejau_consts.vh"
module testbench;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0]  hsize = `EJAU_HSIZE_WORD;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  int          miscompares = 0;
  int          nTests = 0;
  ejau_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  // 25 ns clock.
  always #12.5 ref_clk = ~ref_clk;
  // ========================================
  // Bus and report helpers.
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded so that a stuck slave ends the run instead of hanging it.
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      tallyAndFinish;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask
  task automatic ex(input logic [2:0] op, input logic [1:0] en, tg, s1, s2, input logic [4:0] sk, input logic [7:0] im);
    wr(`EJAU_OFS_INSTR, {im, 3'h0, sk, 2'h0, s2, s1, tg, 2'h0, en, 1'b0, op});
  endtask
  // ========================================
  // Scenarios.
  task automatic tLoad;
    rdc(`EJAU_OFS_GLOBAL, 32'h0000_0000, "global at reset");
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h5A);
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h11);
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_B, 2'h0, 2'h0, 5'h00, 8'h22);
    rdc(`EJAU_OFS_VARS0, 32'h0000_2211, "engine 0 pair");
    rdc(`EJAU_OFS_VARS1, 32'h0000_0000, "engine 1 pair");
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_C, 2'h0, 2'h0, 5'h00, 8'h33);
    rdc(`EJAU_OFS_STATUS, 32'h0000_3300, "status");
    rdc(`EJAU_OFS_GLOBAL, 32'h0000_0033, "global");
    ex(`EJAU_OPC_ADD_VARS, 2'h1, `EJAU_SEL_A, `EJAU_SEL_C, `EJAU_SEL_C, 5'h00, 8'h00);
    rdc(`EJAU_OFS_VARS1, 32'h0000_0066, "engine 1 sum");
  endtask
  // Sums pass 255; selector 3 follows the alternate-value switch.
  task automatic tAdd;
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'hFF);
    ex(`EJAU_OPC_ADD_IMM, 2'h0, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h20);
    rdc(`EJAU_OFS_VARS0, 32'h0000_221F, "add immediate");
    wr(`EJAU_OFS_DVAR, 32'h0000_00F0);
    ex(`EJAU_OPC_ADD_VARS, 2'h0, `EJAU_SEL_B, `EJAU_SEL_A, `EJAU_SEL_D, 5'h00, 8'h00);
    rdc(`EJAU_OFS_VARS0, 32'h0000_0F1F, "add vars");
    wr(`EJAU_OFS_ALTVAL, 32'h0000_0002);
    wr(`EJAU_OFS_CFG, 32'h0000_0001);
    ex(`EJAU_OPC_ADD_VARS, 2'h0, `EJAU_SEL_C, `EJAU_SEL_B, `EJAU_SEL_D, 5'h00, 8'h00);
    rdc(`EJAU_OFS_GLOBAL, 32'h0000_0011, "alternate source");
  endtask
  // Each compare code, true and false; 200 against 3 exposes a signed compare.
  task automatic tJump;
    logic [7:0] v[2];
    logic [1:0] p1[3];
    logic [1:0] p2[3];
    logic [6:0] pc;
    logic [4:0] sk;
    logic       tk;
    v = '{8'h03, 8'hC8};
    p1 = '{2'h0, 2'h0, 2'h1};
    p2 = '{2'h1, 2'h0, 2'h0};
    ex(`EJAU_OPC_LOAD, 2'h2, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h03);
    ex(`EJAU_OPC_LOAD, 2'h2, `EJAU_SEL_B, 2'h0, 2'h0, 5'h00, 8'hC8);
    wr(`EJAU_OFS_PC2, 32'h0000_0000);
    pc = 7'h00;
    for (int op = 1; op <= 4; op++) begin
      for (int i = 0; i < 3; i++) begin
        case (op)
          1: tk = v[p1[i]] != v[p2[i]];
          2: tk = v[p1[i]] < v[p2[i]];
          3: tk = v[p1[i]] >= v[p2[i]];
          default: tk = v[p1[i]] == v[p2[i]];
        endcase
        sk = 5'h1F - 5'(op * i);
        ex(3'(op), 2'h2, 2'h0, p1[i], p2[i], sk, 8'h00);
        pc = pc + 7'h01 + (tk ? {2'h0, sk} : 7'h00);
        rdc(`EJAU_OFS_PC2, {25'h0, pc}, "engine 2 counter");
      end
    end
    ex(`EJAU_OPC_SKIP_EQ, 2'h2, 2'h0, 2'h0, 2'h0, 5'h00, 8'h00);
    rdc(`EJAU_OFS_PC2, {25'h0, pc + 7'h01}, "zero skip");
  endtask
  // Nop, refused engine and target codes, the taken flag and a dropped narrow write.
  task automatic tReject;
    wr(`EJAU_OFS_PC0, 32'h0000_0010);
    ex(`EJAU_OPC_NOP, 2'h0, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h99);
    ex(`EJAU_OPC_LOAD, 2'h0, `EJAU_SEL_D, 2'h0, 2'h0, 5'h00, 8'h77);
    ex(`EJAU_OPC_LOAD, 2'h3, `EJAU_SEL_A, 2'h0, 2'h0, 5'h00, 8'h55);
    rdc(`EJAU_OFS_INSTR, 32'h5500_0035, "last instruction word");
    rdc(`EJAU_OFS_STATUS, 32'h0000_C802, "rejected status");
    rdc(`EJAU_OFS_VARS0, 32'h0000_0F1F, "engine 0 untouched");
    rdc(`EJAU_OFS_PC0, 32'h0000_0011, "engine 0 counter");
    ex(`EJAU_OPC_SKIP_GE, 2'h0, 2'h0, `EJAU_SEL_A, `EJAU_SEL_B, 5'h02, 8'h00);
    rdc(`EJAU_OFS_PC0, 32'h0000_0014, "engine 0 taken jump");
    rdc(`EJAU_OFS_STATUS, 32'h0000_C801, "taken status");
    hsize <= 3'h1;
    wr(`EJAU_OFS_GLOBAL, 32'h0000_00AA);
    hsize <= `EJAU_HSIZE_WORD;
    rdc(`EJAU_OFS_GLOBAL, 32'h0000_0011, "narrow write dropped");
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tLoad;
    tAdd;
    tJump;
    tReject;
    tallyAndFinish;
  end
endmodule // testbench
bind ejau_top ejau_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));
